// ==== drive_control_word_decoder.sv ====
// Holding register functions and command word decoding of a drive port
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - Read answers the requested count of consecutive holding registers
// - Frame register addresses are zero based; register number is address+1
// - Each register answered as high byte first, then low byte
// - Preset writes the 16-bit value into the addressed register
// - Preset answer echoes the query after the store has happened
// - Word bits 1:0 pick one of four preset references
// - Bit 2 low gives DC braking and stop
// - Bit 3 low switches the output stage off at once
// - Bit 4 low makes a quick stop ramp
// - Bit 5 low freezes the output frequency
// - While frozen only coast or DC brake sources stop the motor
// - Bit 6 low makes a ramp stop
// - Trip reset only on a rising edge of bit 7
// - Bit 8 high runs at the inching speed
// - Bit 9 picks the second ramp pair
// - Bit 10 low makes the whole word ignored
// - Bit 11 drives the first relay when configured to follow
// - Bit 12 drives the second relay when configured to follow
// - Bits 14:13 pick one of four set-ups
// - Set-up bits act only in multiple set-up mode
// - Bit 15 reverses only for serial, OR or AND reversing source
// - Parameter number is register number divided by ten
module drive_control_word_decoder
   import drive_cmd_pkg::*;
(
   input  wire logic                     clock,          // 20 MHz clock
   input  wire logic                     reset_n,        // Sync, active low
   input  wire logic                     req_valid,      // Query present
   output logic                          req_ready,      // Query taken
   input  wire logic [7:0]               req_func,       // Function code
   input  wire logic [15:0]              req_addr,       // Zero based addr
   input  wire logic [15:0]              req_arg,        // Count or value
   output logic                          rsp_valid,      // Answer byte
   input  wire logic                     rsp_ready,      // Byte accepted
   output logic      [7:0]               rsp_byte,       // Answer data
   output logic                          rsp_last,       // Last byte
   input  wire logic                     relay1_follow,  // Relay 1 config
   input  wire logic                     relay2_follow,  // Relay 2 config
   input  wire logic                     multi_setup,    // Multi set-up
   input  wire drive_cmd_pkg::rev_src_e  reverse_src,    // Reverse source
   input  wire logic                     reverse_din,    // Reverse input
   input  wire logic                     din_dc_brake,   // DC brake input
   input  wire logic                     din_coast,      // Coast input
   output logic      [1:0]               preset_ref_sel, // Reference pick
   output logic                          dc_brake,       // DC brake stop
   output logic                          output_off,     // Stage off
   output logic                          quick_stop,     // Quick ramp
   output logic                          freeze_freq,    // Hold freq
   output logic                          ramp_stop,      // Ramp to stop
   output logic                          trip_reset,     // Pulse
   output logic                          inching_select, // Inching speed
   output logic                          ramp_set2,      // Ramp pair 2
   output logic                          relay1,         // Relay 1
   output logic                          relay2,         // Relay 2
   output logic      [1:0]               setup_sel,      // Set-up pick
   output logic                          reverse,        // Reverse
   output logic      [15:0]              param_num       // Last param no.
);
   import drive_cmd_pkg::*;

   // Checks below share the one clock and the sync reset
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   typedef struct packed {
      state_e              st;
      logic [2:0]          idx;
      logic [7:0]          func;
      logic [15:0]         addr;
      logic [15:0]         arg;
      logic [7:0]          exc;
      logic [MEM_AW-1:0]   ptr;
      logic [15:0]         remain;
      logic [15:0]         cmd;
      logic                req_ready;
      logic                rsp_valid;
      logic [7:0]          rsp_byte;
      logic                rsp_last;
      logic [1:0]          preset_ref;
      logic                dc_brake;
      logic                output_off;
      logic                quick_stop;
      logic                freeze;
      logic                ramp_stop;
      logic                trip_reset;
      logic                inching;
      logic                ramp2;
      logic                relay1;
      logic                relay2;
      logic [1:0]          setup;
      logic                reverse;
      logic [15:0]         param_num;
   } state_s;

   state_s              r_q;
   state_s              r_d;
   logic                accept;
   logic                fire;
   logic                cmd_take;
   logic                wr_en;
   logic [MEM_AW-1:0]   wr_index;
   logic                rd_en;
   logic [MEM_AW-1:0]   rd_index;
   logic [15:0]         rd_data;

   // Register number of a zero based frame address
   function automatic logic [16:0] reg_num(input logic [15:0] a);
      reg_num = {1'b0, a} + REG_ADDR_OFFSET;
   endfunction

   // Whole span of registers lies inside the parameter window
   function automatic logic in_window(input logic [15:0] a,
                                      input logic [15:0] n);
      logic [16:0] last;
      last = reg_num(a) + {1'b0, n} - REG_ADDR_OFFSET;
      in_window = (reg_num(a) >= MEM_BASE_NUM) && (last < MEM_LIMIT_NUM);
   endfunction

   // Word index inside the window
   function automatic logic [MEM_AW-1:0] mem_index(input logic [15:0] a);
      logic [16:0] d;
      d = reg_num(a) - MEM_BASE_NUM;
      mem_index = d[MEM_AW-1:0];
   endfunction

   assign accept   = req_valid & r_q.req_ready;
   assign fire     = r_q.rsp_valid & rsp_ready;
   assign rd_index = r_q.ptr;
   assign rd_en    = (r_q.st == ST_FETCH);
   // Preset aimed at the command word, whatever its valid bit
   assign cmd_take = accept && (req_func == FN_PRESET_ONE)
                     && (reg_num(req_addr) == CMD_REG_NUM);

   // Sequencer, command store and decode
   always_comb
   begin
      r_d        = r_q;
      wr_en      = 1'b0;
      wr_index   = mem_index(req_addr);
      r_d.trip_reset = 1'b0;
      case (r_q.st)
         ST_IDLE:
         begin
            if (accept)
            begin
               r_d.req_ready = 1'b0;
               r_d.func      = req_func;
               r_d.addr      = req_addr;
               r_d.arg       = req_arg;
               r_d.idx       = IDX_FIRST;
               r_d.rsp_valid = 1'b1;
               r_d.rsp_last  = 1'b0;
               r_d.rsp_byte  = req_func;
               r_d.param_num = 16'(reg_num(req_addr) / PNU_SCALE);
               r_d.st        = ST_EXC;
               r_d.rsp_byte  = req_func | EXC_FLAG;
               if (req_func == FN_READ_HOLD)
               begin
                  if ((req_arg == ZERO_REGS) || (req_arg > MAX_READ_REGS))
                  begin
                     r_d.exc = EXC_ILL_VALUE;
                  end
                  else if (!in_window(req_addr, req_arg))
                  begin
                     r_d.exc = EXC_ILL_ADDR;
                  end
                  else
                  begin
                     r_d.st       = ST_HDR;
                     r_d.rsp_byte = req_func;
                     r_d.ptr      = mem_index(req_addr);
                     r_d.remain   = req_arg;
                  end
               end
               else if (req_func == FN_PRESET_ONE)
               begin
                  if (cmd_take)
                  begin
                     r_d.st       = ST_ECHO;
                     r_d.rsp_byte = req_func;
                     // Invalid words leave drive control untouched
                     if (req_arg[CW_VALID])
                     begin
                        r_d.cmd = req_arg;
                        r_d.trip_reset = req_arg[CW_RESET]
                                         & ~r_q.cmd[CW_RESET];
                     end
                  end
                  else if (in_window(req_addr, ONE_REG))
                  begin
                     wr_en        = 1'b1;
                     r_d.st       = ST_ECHO;
                     r_d.rsp_byte = req_func;
                  end
                  else
                  begin
                     r_d.exc = EXC_ILL_ADDR;
                  end
               end
               else
               begin
                  r_d.exc = EXC_ILL_FUNC;
               end
            end
         end
         ST_HDR:
         begin
            if (fire)
            begin
               if (r_q.idx == IDX_FIRST)
               begin
                  r_d.rsp_byte = {r_q.remain[6:0], 1'b0};
                  r_d.idx      = IDX_HDR_LAST;
               end
               else
               begin
                  r_d.rsp_valid = 1'b0;
                  r_d.st        = ST_FETCH;
               end
            end
         end
         ST_FETCH:
         begin
            r_d.st = ST_WAIT;
         end
         ST_WAIT:
         begin
            r_d.rsp_valid = 1'b1;
            r_d.rsp_byte  = rd_data[15:8];
            r_d.st        = ST_DHI;
         end
         ST_DHI:
         begin
            if (fire)
            begin
               r_d.rsp_byte = rd_data[7:0];
               r_d.rsp_last = (r_q.remain == ONE_REG);
               r_d.st       = ST_DLO;
            end
         end
         ST_DLO:
         begin
            if (fire)
            begin
               r_d.rsp_valid = 1'b0;
               r_d.rsp_last  = 1'b0;
               // Consecutive registers, lowest number first
               if (r_q.remain == ONE_REG)
               begin
                  r_d.st        = ST_IDLE;
                  r_d.req_ready = 1'b1;
               end
               else
               begin
                  r_d.remain = r_q.remain - ONE_REG;
                  r_d.ptr    = r_q.ptr + MEM_AW'(1);
                  r_d.st     = ST_FETCH;
               end
            end
         end
         ST_ECHO:
         begin
            // Echo starts only after the store edge
            if (fire)
            begin
               r_d.idx = r_q.idx + IDX_STEP;
               case (r_q.idx)
                  3'h0:    r_d.rsp_byte = r_q.addr[15:8];
                  3'h1:    r_d.rsp_byte = r_q.addr[7:0];
                  3'h2:    r_d.rsp_byte = r_q.arg[15:8];
                  3'h3:    r_d.rsp_byte = r_q.arg[7:0];
                  default: r_d.rsp_byte = r_q.rsp_byte;
               endcase
               r_d.rsp_last = (r_q.idx == IDX_ECHO_LAST - IDX_STEP);
               if (r_q.idx == IDX_ECHO_LAST)
               begin
                  r_d.rsp_valid = 1'b0;
                  r_d.rsp_last  = 1'b0;
                  r_d.req_ready = 1'b1;
                  r_d.st        = ST_IDLE;
               end
            end
         end
         ST_EXC:
         begin
            if (fire)
            begin
               if (r_q.idx == IDX_FIRST)
               begin
                  r_d.rsp_byte = r_q.exc;
                  r_d.rsp_last = 1'b1;
                  r_d.idx      = IDX_EXC_LAST;
               end
               else
               begin
                  r_d.rsp_valid = 1'b0;
                  r_d.rsp_last  = 1'b0;
                  r_d.req_ready = 1'b1;
                  r_d.st        = ST_IDLE;
               end
            end
         end
         default:
         begin
            r_d.st        = ST_IDLE;
            r_d.rsp_valid = 1'b0;
            r_d.req_ready = 1'b1;
         end
      endcase

      // Decode from the stored word and the digital inputs, so actions switch as one
      r_d.preset_ref = r_q.cmd[CW_REF_MSB:CW_REF_LSB];
      r_d.dc_brake   = ~r_q.cmd[CW_DC_RAMP] | din_dc_brake;
      r_d.output_off = ~r_q.cmd[CW_NO_COAST] | din_coast;
      r_d.freeze     = ~r_q.cmd[CW_USE_RAMP];
      // Frozen frequency blocks the ramped stops
      r_d.quick_stop = ~r_q.cmd[CW_NO_QSTOP] & r_q.cmd[CW_USE_RAMP];
      r_d.ramp_stop  = ~r_q.cmd[CW_START] & r_q.cmd[CW_USE_RAMP];
      r_d.inching    = r_q.cmd[CW_JOG];
      r_d.ramp2      = r_q.cmd[CW_RAMP2];
      r_d.relay1     = relay1_follow & r_q.cmd[CW_RELAY1];
      r_d.relay2     = relay2_follow & r_q.cmd[CW_RELAY2];
      if (multi_setup)
      begin
         r_d.setup = r_q.cmd[CW_SETUP_MSB:CW_SETUP_LSB];
      end
      case (reverse_src)
         REV_SERIAL: r_d.reverse = r_q.cmd[CW_REVERSE];
         REV_OR:     r_d.reverse = r_q.cmd[CW_REVERSE] | reverse_din;
         REV_AND:    r_d.reverse = r_q.cmd[CW_REVERSE] & reverse_din;
         default:    r_d.reverse = reverse_din;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         r_q           <= '0;
         r_q.st        <= ST_IDLE;
         r_q.cmd       <= CMD_RESET;
         r_q.req_ready <= 1'b1;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   holding_ram u_ram (
      .clock    (clock),
      .reset_n  (reset_n),
      .wr_en    (wr_en),
      .wr_index (wr_index),
      .wr_data  (req_arg),
      .rd_en    (rd_en),
      .rd_index (rd_index),
      .rd_data  (rd_data)
   );

   // Ports straight from the state register
   assign req_ready      = r_q.req_ready;
   assign rsp_valid      = r_q.rsp_valid;
   assign rsp_byte       = r_q.rsp_byte;
   assign rsp_last       = r_q.rsp_last;
   assign preset_ref_sel = r_q.preset_ref;
   assign dc_brake       = r_q.dc_brake;
   assign output_off     = r_q.output_off;
   assign quick_stop     = r_q.quick_stop;
   assign freeze_freq    = r_q.freeze;
   assign ramp_stop      = r_q.ramp_stop;
   assign trip_reset     = r_q.trip_reset;
   assign inching_select = r_q.inching;
   assign ramp_set2      = r_q.ramp2;
   assign relay1         = r_q.relay1;
   assign relay2         = r_q.relay2;
   assign setup_sel      = r_q.setup;
   assign reverse        = r_q.reverse;
   assign param_num      = r_q.param_num;

   // Checks on answers and decoded actions
   byte_count_a: assert property ((r_q.st == ST_HDR)
      && (r_q.idx == 3'h1) |-> rsp_byte == {r_q.remain[6:0], 1'b0})
      else $error("byte count differs from register count");
   zero_base_a: assert property ((r_q.st == ST_IDLE) && accept
      && (req_func == FN_READ_HOLD) && r_d.st == ST_HDR
      |=> ##1 rd_index == mem_index($past(req_addr, 2)))
      else $error("first read index not address plus one");
   // Read word stays put from the fetch until the low byte is gone
   high_first_a: assert property ((r_q.st == ST_DHI) && fire
      |-> rsp_byte == rd_data[15:8] ##1 rsp_byte == rd_data[7:0])
      else $error("register bytes out of order");
   preset_store_a: assert property (accept && wr_en
      |=> u_ram.m_q.words[$past(wr_index)] == $past(req_arg))
      else $error("preset value not stored");
   echo_after_a: assert property (accept
      && (req_func == FN_PRESET_ONE) && (r_d.st == ST_ECHO)
      |=> rsp_valid && rsp_byte == $past(req_func) && req_ready == 1'b0)
      else $error("echo does not open with the function code");
   trip_edge_a: assert property (trip_reset
      |-> r_q.cmd[CW_RESET] && !$past(r_q.cmd[CW_RESET]) && $past(cmd_take))
      else $error("trip reset without rising edge");
   invalid_word_a: assert property (cmd_take && !req_arg[CW_VALID]
      |=> $stable(r_q.cmd)
      ##1 ($stable(reverse) || reverse_src != REV_SERIAL))
      else $error("invalid command word was applied");
   frozen_stop_a: assert property (freeze_freq
      |-> !quick_stop && !ramp_stop)
      else $error("ramped stop while frequency frozen");
   coast_off_a: assert property (!r_q.cmd[CW_NO_COAST]
      |=> output_off)
      else $error("output stage not off on coasting");
   relay_gate_a: assert property (relay1
      |-> $past(relay1_follow) && $past(r_q.cmd[CW_RELAY1]))
      else $error("relay 1 active without its cause");
   setup_hold_a: assert property (!multi_setup
      |=> $stable(setup_sel))
      else $error("set-up changed outside multi set-up mode");
   reverse_dflt_a: assert property (reverse_src == REV_DIGITAL
      |=> reverse == $past(reverse_din))
      else $error("serial bit reversed under digital source");

   read_done_c: cover property ((r_q.st == ST_DLO) && fire && rsp_last);
   echo_done_c: cover property ((r_q.st == ST_ECHO) && fire && rsp_last);
   trip_c:      cover property (trip_reset);
   exc_c:       cover property ((r_q.st == ST_EXC) && fire && rsp_last);

endmodule // drive_control_word_decoder
`default_nettype wire

// ==== drive_cmd_pkg.sv ====
// Constants, encodings and types shared by the command word decoder
package drive_cmd_pkg;

   // Function codes and exception answers
   localparam logic [7:0]  FN_READ_HOLD   = 8'h03;
   localparam logic [7:0]  FN_PRESET_ONE  = 8'h06;
   localparam logic [7:0]  EXC_FLAG       = 8'h80;
   localparam logic [7:0]  EXC_ILL_FUNC   = 8'h01;
   localparam logic [7:0]  EXC_ILL_ADDR   = 8'h02;
   localparam logic [7:0]  EXC_ILL_VALUE  = 8'h03;

   // Frame address plus this offset gives the register number
   localparam logic [16:0] REG_ADDR_OFFSET = 17'h00001;
   // Register number divided by this gives the parameter number
   localparam logic [16:0] PNU_SCALE       = 17'h0000A;

   // Parameter holding register window
   localparam int          MEM_DEPTH      = 16;
   localparam int          MEM_AW         = 4;
   localparam logic [16:0] MEM_BASE_NUM   = 17'h00BD6;
   localparam logic [16:0] MEM_LIMIT_NUM  = 17'h00BE6;
   localparam logic [15:0] MAX_READ_REGS  = 16'h000A;
   localparam logic [15:0] ZERO_REGS      = 16'h0000;
   localparam logic [15:0] ONE_REG        = 16'h0001;

   // Command word register number and reset value
   localparam logic [16:0] CMD_REG_NUM    = 17'h00001;
   localparam logic [15:0] CMD_RESET      = 16'h0000;

   // Command word bit positions
   localparam int CW_REF_LSB   = 0;
   localparam int CW_REF_MSB   = 1;
   localparam int CW_DC_RAMP   = 2;
   localparam int CW_NO_COAST  = 3;
   localparam int CW_NO_QSTOP  = 4;
   localparam int CW_USE_RAMP  = 5;
   localparam int CW_START     = 6;
   localparam int CW_RESET     = 7;
   localparam int CW_JOG       = 8;
   localparam int CW_RAMP2     = 9;
   localparam int CW_VALID     = 10;
   localparam int CW_RELAY1    = 11;
   localparam int CW_RELAY2    = 12;
   localparam int CW_SETUP_LSB = 13;
   localparam int CW_SETUP_MSB = 14;
   localparam int CW_REVERSE   = 15;

   // Byte index of the first byte, of the last header byte and of the last byte of each other answer, and the step
   localparam logic [2:0] IDX_FIRST     = 3'h0;
   localparam logic [2:0] IDX_HDR_LAST  = 3'h1;
   localparam logic [2:0] IDX_EXC_LAST  = 3'h1;
   localparam logic [2:0] IDX_ECHO_LAST = 3'h4;
   localparam logic [2:0] IDX_STEP      = 3'h1;

   // Answer sequencer states, Gray along the read path except the ST_DLO to ST_IDLE return
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_HDR   = 3'b001,
      ST_FETCH = 3'b011,
      ST_WAIT  = 3'b010,
      ST_DHI   = 3'b110,
      ST_DLO   = 3'b111,
      ST_ECHO  = 3'b101,
      ST_EXC   = 3'b100
   } state_e;

   // Source of the reversing command
   typedef enum logic [1:0] {
      REV_DIGITAL = 2'b00,
      REV_SERIAL  = 2'b01,
      REV_OR      = 2'b10,
      REV_AND     = 2'b11
   } rev_src_e;

endpackage

// ==== holding_ram.sv ====
// Parameter holding register store with registered read data
`timescale 1ns/1ps
`default_nettype none
module holding_ram
   import drive_cmd_pkg::*;
(
   input  wire logic              clock,    // 20 MHz clock
   input  wire logic              reset_n,  // Sync reset, active low
   input  wire logic              wr_en,    // Write strobe
   input  wire logic [MEM_AW-1:0] wr_index, // Write word index
   input  wire logic [15:0]       wr_data,  // Write word
   input  wire logic              rd_en,    // Read strobe
   input  wire logic [MEM_AW-1:0] rd_index, // Read word index
   output logic      [15:0]       rd_data   // Read word, next cycle
);

   typedef struct packed {
      logic [MEM_DEPTH-1:0][15:0] words;
      logic [15:0]                rd;
   } ram_s;

   ram_s m_q;
   ram_s m_d;

   // Write and read; read returns old word on a same-index collision
   always_comb
   begin
      m_d = m_q;
      if (wr_en)
      begin
         m_d.words[wr_index] = wr_data;
      end
      if (rd_en)
      begin
         m_d.rd = m_q.words[rd_index];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         m_q <= '0;
      end
      else
      begin
         m_q <= m_d;
      end
   end

   assign rd_data = m_q.rd;

endmodule // holding_ram
`default_nettype wire

// ==== modbus_master.sv ====
// Modbus master model: issues queries and logs answer bytes
`timescale 1ns/1ps
`default_nettype none
module modbus_master
(
   input  wire logic        clock,     // Clock
   input  wire logic        slow,      // Stall bytes
   input  wire logic        req_ready, // Taken
   output logic             req_valid, // Query
   output logic      [7:0]  req_func,  // Function
   output logic      [15:0] req_addr,  // Address
   output logic      [15:0] req_arg,   // Argument
   input  wire logic        rsp_valid, // Byte valid
   input  wire logic [7:0]  rsp_byte,  // Byte
   input  wire logic        rsp_last,  // Last byte
   output logic             rsp_ready  // Accept
);
   logic [8:0] got [$]; // Last flag and byte of the last answer
   initial {req_valid, req_func, req_addr, req_arg, rsp_ready} = 42'h1;
   // Stalling makes every answer byte stand a second cycle
   always @(posedge clock)
   begin
      rsp_ready <= #1 slow ? ~rsp_ready : 1'b1;
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
         got.push_back({rsp_last, rsp_byte});
   end
   // Held until taken; fields go stale so nothing leans on them
   task query(logic [7:0] f, logic [15:0] a, v);
      got.delete();
      #1 {req_valid, req_func, req_addr, req_arg} = {1'b1, f, a, v};
      do @(posedge clock); while (req_ready !== 1'b1);
      #1 {req_valid, req_func, req_addr, req_arg} = {1'b0, ~f, ~a, ~v};
      do @(posedge clock); while (req_ready !== 1'b1);
   endtask
endmodule // modbus_master
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench of the command word decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import drive_cmd_pkg::*;
   logic clock = 1'b0, reset_n = 1'b0, slow = 1'b0, din_coast = 1'b0;
   logic relay1_follow = 1'b1, relay2_follow = 1'b1, multi_setup = 1'b1;
   logic reverse_din = 1'b0, din_dc_brake = 1'b0, relay2, inching_select;
   rev_src_e reverse_src = REV_SERIAL;
   logic req_valid, req_ready, rsp_valid, rsp_ready, rsp_last, dc_brake;
   logic output_off, quick_stop, freeze_freq, ramp_stop, trip_reset;
   logic ramp_set2, relay1, reverse;
   logic [1:0] preset_ref_sel, setup_sel;
   logic [7:0] req_func, rsp_byte;
   logic [15:0] req_addr, req_arg, param_num;
   int fails = 0, n_checks = 0, cyc = 0, trips = 0, n0;
   wire logic [15:0] seen_v = {2'b00, preset_ref_sel, dc_brake, output_off,
      quick_stop, freeze_freq, ramp_stop, inching_select, ramp_set2, relay1,
      relay2, setup_sel, reverse};
   wire logic [3:0] stop_v = {dc_brake, output_off, freeze_freq, reverse};
   // Decoder facing the master model, clock at 50 ns
   drive_control_word_decoder DUT (.*);
   modbus_master m (.*);
   always #25 clock = ~clock;
   task check(string nm, logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp)
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      fails += int'(seen !== exp);
   endtask
   // Length first, then each byte with the last flag on the final one
   task cmp(logic [7:0] e [$]);
      check("len", 16'(m.got.size()), 16'(e.size()));
      foreach (e[i])
         check("byte", {7'h00, m.got[i]},
            {7'h00, i == e.size() - 1, e[i]});
   endtask
   task wr(logic [15:0] a, v);
      m.query(FN_PRESET_ONE, a, v);
      cmp('{FN_PRESET_ONE, a[15:8], a[7:0], v[15:8], v[7:0]});
   endtask
   function logic [15:0] dec(logic [15:0] w);
      return {2'b00, w[1:0], ~w[2], ~w[3], ~w[4] & w[5], ~w[5],
         ~w[6] & w[5], w[8], w[9], w[11], w[12], w[14:13], w[15]};
   endfunction
   // Trip pulse tally; the ceiling cuts a hung run short
   always @(posedge clock)
   begin
      trips <= trips + int'(trip_reset === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 3000)
         summarize(1);
   end
   task summarize(int x);
      fails += x;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task t_param();
      wr(16'h0BD5, 16'h0016);
      wr(16'h0BD6, 16'hE360);
      slow <= 1'b1;
      m.query(FN_READ_HOLD, 16'h0BD5, 16'h0002);
      cmp('{8'h03, 8'h04, 8'h00, 8'h16, 8'hE3, 8'h60});
      check("pnu", param_num, 16'h012F);
   endtask
   task t_cmd();
      static logic [15:0] w [7] = '{16'h0400, 16'h0480, 16'h0480, 16'hFFFF,
         16'h4C25, 16'hB7D6, 16'h2E5B};
      n0 = trips;
      foreach (w[i])
      begin
         wr(16'h0000, w[i]);
         check("w", seen_v, dec(w[i]));
      end
      // Ignored word would give a third trip edge
      wr(16'h0000, 16'h03FF);
      check("ignored", seen_v, dec(16'h2E5B));
      check("trips", 16'(trips - n0), 16'h0002);
      {relay1_follow, multi_setup, reverse_din} <= 3'b001;
      reverse_src <= REV_DIGITAL;
      wr(16'h0000, 16'hFFFF);
      check("relays", {14'h0000, relay1, relay2}, 16'h0001);
      check("setup", {13'h0000, setup_sel, reverse}, 16'h0003);
   endtask
   // Refused queries answer with the flagged function and a code
   task t_exc();
      m.query(8'h10, 16'h0BD5, 16'h0002);
      cmp('{8'h90, EXC_ILL_FUNC});
      m.query(FN_READ_HOLD, 16'h0000, ONE_REG);
      cmp('{8'h83, EXC_ILL_ADDR});
      m.query(FN_READ_HOLD, 16'h0BD5, ZERO_REGS);
      cmp('{8'h83, EXC_ILL_VALUE});
      m.query(FN_PRESET_ONE, 16'h0BE5, 16'h1234);
      cmp('{8'h86, EXC_ILL_ADDR});
   endtask
   // Digital stop inputs while frozen under AND reversing, then OR reversing
   task t_din();
      {din_dc_brake, din_coast} <= 2'b11;
      reverse_src <= REV_AND;
      wr(16'h0000, 16'h7FDF);
      check("din", {12'h000, stop_v}, 16'h000E);
      {din_dc_brake, din_coast} <= 2'b00;
      reverse_src <= REV_OR;
      repeat (2) @(posedge clock);
      check("or", {12'h000, stop_v}, 16'h0003);
   endtask
   // Reset, then the scenarios in turn
   initial
   begin
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      t_param();
      t_exc();
      t_cmd();
      t_din();
      summarize(0);
   end
endmodule // testbench
`default_nettype wire
